// file: rtl/plc_phy_end.sv
// phy end: grant hand-over, null/cancel detection, self-id power class
`timescale 1ns/1ps
module plc_phy_end #(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  // interface to link
  plc_if.phy                 bus,
  // user side
  input  wire logic          i_grant_req,
  input  wire logic [2:0]    i_power_class_straps,
  input  wire logic          i_pwr_wr,
  input  wire logic [2:0]    i_pwr_wdata,
  output logic               o_busy,
  output logic               o_done_pulse,
  output logic               o_null_pulse,
  output logic               o_concat_pulse,
  output logic [31:0]        o_self_id
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // only 2, 4 and 8 data lines have a lane mapping on the link side
  if (DW != 2 && DW != 4 && DW != 8)
  begin : g_bad_dw
    $error("data width must be 2, 4 or 8");
  end

  // the class field has to sit inside the self-id word
  if (plc_pkg::PWR_LSB + plc_pkg::PWR_W > $bits(o_self_id))
  begin : g_bad_pwr_field
    $error("power class field outside the self-id word");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  typedef enum logic [2:0] {S_IDLE, S_GRANT, S_GIDLE, S_LINK, S_TAIL, S_REIDLE}
    plc_phy_state_e;
  plc_phy_state_e state;
  plc_phy_state_e next_state;

  // line decode
  logic [1:0]       line_code;
  logic             in_idle;
  logic             in_hold;
  logic             in_xmit;

  // link-phase tracking
  logic             prev_idle;
  logic             next_prev_idle;
  logic             saw_xmit;
  logic             next_saw_xmit;

  // next values of the registered outputs
  logic             drive;
  logic [1:0]       next_ctrl;
  logic             next_busy;
  logic             next_done;
  logic             next_null;
  logic             next_concat;
  logic [2:0]       pwr_class;
  wire logic [31:0] next_self_id;

  ////////////////////////////////////////////////////////////////////////////
  // line decode
  assign line_code = bus.iface_ctrl_lines;
  assign in_idle   = line_code == plc_pkg::LINE_IDLE;   // RULE2
  assign in_hold   = line_code == plc_pkg::LINE_HOLD;   // RULE2
  assign in_xmit   = line_code == plc_pkg::LINE_XMIT;   // RULE2

  ////////////////////////////////////////////////////////////////////////////
  // power class: straps at reset, software write after
  plc_pwr_class u_pwr (
    .i_clk_sys            (i_clk_sys),
    .i_rst                (i_rst),
    .i_power_class_straps (i_power_class_straps),
    .i_pwr_wr             (i_pwr_wr),
    .i_pwr_wdata          (i_pwr_wdata),
    .o_pwr_class          (pwr_class)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state transitions
  // the link phase ends when its second idle in a row is seen; a request
  // that arrives while busy is simply not looked at
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:   if (i_grant_req) next_state = S_GRANT;
      S_GRANT:  next_state = S_GIDLE;                          // RULE3
      S_GIDLE:  next_state = S_LINK;                           // RULE1
      S_LINK:   if (in_idle && prev_idle) next_state = S_TAIL; // RULE6
      S_TAIL:   next_state = S_REIDLE;
      S_REIDLE: next_state = S_IDLE;                           // RULE8
      default:  next_state = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next values
  // phy drives in every state but the link phase and the turn-around; the
  // extra undriven cycle lets both ends work from registered lines
  assign drive = next_state != S_LINK && next_state != S_TAIL;   // RULE1

  // grant for one cycle, idle in every other driven cycle
  assign next_ctrl = (next_state == S_GRANT) ? plc_pkg::LINE_GRANT   // RULE3
                                             : plc_pkg::LINE_IDLE;   // RULE8

  // a leading idle right after hand-over counts toward the pair
  assign next_prev_idle = (state == S_LINK) && in_idle;

  // cleared as the lines are handed over, set by any transmit cycle
  assign next_saw_xmit = (state == S_GIDLE)           ? 1'b0 :
                         (state == S_LINK && in_xmit) ? 1'b1 : saw_xmit;

  // busy covers the re-idle cycle, so a new request waits for it
  assign next_busy   = next_state != S_IDLE;
  assign next_done   = state == S_TAIL;
  // no transmit seen: ownership ends without packet data
  assign next_null   = (state == S_TAIL) && !saw_xmit;            // RULE13
  // hold after transmit asks for a concatenated packet
  assign next_concat = (state == S_LINK) && in_hold && saw_xmit;

  ////////////////////////////////////////////////////////////////////////////
  // self-id word: class bits in their field, every other bit zero
  for (genvar b = 0; b < $bits(o_self_id); b++)
  begin : g_self_id
    if (b >= plc_pkg::PWR_LSB && b < plc_pkg::PWR_LSB + plc_pkg::PWR_W)
    begin : g_class_bit
      assign next_self_id[b] = pwr_class[b - plc_pkg::PWR_LSB];   // RULE9
    end
    else
    begin : g_zero_bit
      assign next_self_id[b] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and link-phase tracking
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state     <= S_IDLE;
      prev_idle <= 1'b0;
      saw_xmit  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      prev_idle <= next_prev_idle;
      saw_xmit  <= next_saw_xmit;
    end
  end

  // interface lines: released under reset so the link sees no stray code
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      bus.phy_ctrl_o    <= plc_pkg::LINE_IDLE;
      bus.phy_ctrl_oe_n <= 1'b1;
      bus.phy_data_o    <= '0;
    end
    else
    begin
      bus.phy_ctrl_o    <= next_ctrl;
      bus.phy_ctrl_oe_n <= !drive;                              // RULE1
      // no packet data flows from this end in this block
      bus.phy_data_o    <= '0;
    end
  end

  // user-side status pulses and level
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_busy         <= 1'b0;
      o_done_pulse   <= 1'b0;
      o_null_pulse   <= 1'b0;
      o_concat_pulse <= 1'b0;
    end
    else
    begin
      o_busy         <= next_busy;
      o_done_pulse   <= next_done;
      o_null_pulse   <= next_null;
      o_concat_pulse <= next_concat;
    end
  end

  // self-id word follows the class every cycle, so a later software write
  // shows in the next packet without waiting for a bus reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_self_id <= '0;
    end
    else
    begin
      o_self_id <= next_self_id;                               // RULE10
    end
  end
endmodule : plc_phy_end

// file: include/plc_pkg.sv
// shared constants for the phy/link null-transmit handshake and power class
// Contract
// RULE1 - grant, then idle, then release lines
// RULE2 - idle 00, hold 01, transmit 10
// RULE3 - grant held exactly one clock cycle
// RULE4 - link drives at most one leading idle
// RULE5 - link holds zero to 47 cycles
// RULE6 - link ends with two idles, releases
// RULE7 - no hold: link drives three idles (the link drives two when no leading idle is asked for)
// RULE8 - phy drives idle before next operation
// RULE9 - strap value goes into self-id bits 21-23
// RULE10 - straps load on reset; software overrides
// RULE11 - classes 000 to 011 self powered
// RULE12 - classes 100 to 111 bus powered
// RULE13 - idle without transmit ends ownership
package plc_pkg;
  localparam logic [1:0] LINE_IDLE  = 2'h0;
  localparam logic [1:0] LINE_HOLD  = 2'h1;
  localparam logic [1:0] LINE_XMIT  = 2'h2;
  localparam logic [1:0] LINE_GRANT = 2'h3;
  localparam int         MAX_HOLD  = 47;
  localparam int         PWR_LSB   = 21;
  localparam int         PWR_W     = 3;
  localparam logic [2:0] PC_NONE       = 3'h0; // RULE11
  localparam logic [2:0] PC_SELF_15W   = 3'h1; // RULE11
  localparam logic [2:0] PC_SELF_30W   = 3'h2; // RULE11
  localparam logic [2:0] PC_SELF_45W   = 3'h3; // RULE11
  localparam logic [2:0] PC_BUS_3W     = 3'h4; // RULE12
  localparam logic [2:0] PC_BUS_LINK0  = 3'h5; // RULE12
  localparam logic [2:0] PC_BUS_LINK3  = 3'h6; // RULE12
  localparam logic [2:0] PC_BUS_LINK7  = 3'h7; // RULE12
endpackage : plc_pkg

// file: include/plc_if.sv
// phy-link parallel interface: shared control and data lines
`timescale 1ns/1ps
interface plc_if #(parameter int DW = 8);
  logic [1:0]    phy_ctrl_o;
  logic          phy_ctrl_oe_n;
  logic [DW-1:0] phy_data_o;
  logic [1:0]    lnk_ctrl_o;
  logic          lnk_ctrl_oe_n;
  logic [DW-1:0] lnk_data_o;
  logic [1:0]    iface_ctrl_lines;
  logic [DW-1:0] iface_data_lines;

  // unpowered lines read as idle / zero (bus holder stand-in)
  assign iface_ctrl_lines = !phy_ctrl_oe_n ? phy_ctrl_o :
                            !lnk_ctrl_oe_n ? lnk_ctrl_o : 2'h0;
  assign iface_data_lines = !phy_ctrl_oe_n ? phy_data_o :
                            !lnk_ctrl_oe_n ? lnk_data_o : '0;

  modport phy (output phy_ctrl_o, phy_ctrl_oe_n, phy_data_o,
               input iface_ctrl_lines, iface_data_lines);
  modport lnk (output lnk_ctrl_o, lnk_ctrl_oe_n, lnk_data_o,
               input iface_ctrl_lines, iface_data_lines);
endinterface : plc_if

// file: rtl/plc_pwr_class.sv
// power-class holder: strap load at reset, software override
`timescale 1ns/1ps
module plc_pwr_class (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // strap pins and software write
  input  wire logic [2:0] i_power_class_straps,
  input  wire logic       i_pwr_wr,
  input  wire logic [2:0] i_pwr_wdata,
  // current class
  output logic      [2:0] o_pwr_class
);
  logic strap_pend;
  logic [2:0] next_pwr;

  // straps caught on the first edge after release, never under reset
  assign next_pwr = i_pwr_wr ? i_pwr_wdata :                     // RULE10
                    strap_pend ? i_power_class_straps : o_pwr_class; // RULE10 RULE11 RULE12

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      strap_pend  <= 1'b1;
      o_pwr_class <= plc_pkg::PC_NONE;
    end
    else
    begin
      strap_pend  <= 1'b0;
      o_pwr_class <= next_pwr;
    end
  end
endmodule : plc_pwr_class

// file: rtl/plc_lnk_end.sv
// link end: answers a grant with idle/hold then cancels (null transmit)
`timescale 1ns/1ps
module plc_lnk_end #(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // interface to phy
  plc_if.lnk              bus,
  // user side
  input  wire logic       i_lead_idle,
  input  wire logic [5:0] i_hold_cycles,
  output logic            o_active,
  output logic            o_done_pulse
);
  // only 2, 4 and 8 data lines have a lane mapping
  if (DW != 2 && DW != 4 && DW != 8)
  begin : g_bad_dw
    $error("data width must be 2, 4 or 8");
  end

  typedef enum logic [2:0] {L_WAIT, L_GIDLE, L_LEAD, L_HOLD, L_END1, L_END2}
    plc_lnk_state_e;
  plc_lnk_state_e state;
  plc_lnk_state_e next_state;

  logic [5:0] hold_cnt;
  logic [5:0] hold_lim;
  logic       drive;

  // clamp to the longest legal hold run
  assign hold_lim = (i_hold_cycles > 6'(plc_pkg::MAX_HOLD)) ?
                    6'(plc_pkg::MAX_HOLD) : i_hold_cycles;   // RULE5

  always_comb
  begin
    next_state = state;
    case (state)
      L_WAIT:  if (bus.iface_ctrl_lines == plc_pkg::LINE_GRANT) next_state = L_GIDLE;
      L_GIDLE: next_state = i_lead_idle ? L_LEAD :           // RULE4
                            (hold_lim != 6'h0) ? L_HOLD : L_END1;
      L_LEAD:  next_state = (hold_lim != 6'h0) ? L_HOLD : L_END1; // RULE7
      L_HOLD:  if (hold_cnt + 6'h1 >= hold_lim) next_state = L_END1;
      L_END1:  next_state = L_END2;                          // RULE6
      L_END2:  next_state = L_WAIT;                          // RULE6
      default: next_state = L_WAIT;
    endcase
  end

  assign drive = next_state inside {L_LEAD, L_HOLD, L_END1, L_END2};

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state          <= L_WAIT;
      hold_cnt       <= 6'h0;
      bus.lnk_ctrl_o <= plc_pkg::LINE_IDLE;
      bus.lnk_ctrl_oe_n <= 1'b1;
      bus.lnk_data_o <= '0;
      o_active       <= 1'b0;
      o_done_pulse   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      hold_cnt <= (state == L_HOLD) ? hold_cnt + 6'h1 : 6'h0;
      bus.lnk_ctrl_o <= (next_state == L_HOLD) ? plc_pkg::LINE_HOLD  // RULE2
                                               : plc_pkg::LINE_IDLE;
      bus.lnk_ctrl_oe_n <= !drive;                           // RULE6
      bus.lnk_data_o <= '0;
      o_active       <= next_state != L_WAIT;
      o_done_pulse   <= state == L_END2;
    end
  end
endmodule : plc_lnk_end

// file: tb/plc_props.sv
// concurrent checks on the phy-link control lines
`timescale 1ns/1ps
module plc_props (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  // interface lines
  input wire logic [1:0] phy_ctrl_o,
  input wire logic       phy_ctrl_oe_n,
  input wire logic [1:0] lnk_ctrl_o,
  input wire logic       lnk_ctrl_oe_n
);
  wire        pg = !phy_ctrl_oe_n && phy_ctrl_o == 2'h3;
  wire        pi = !phy_ctrl_oe_n && phy_ctrl_o == 2'h0;
  wire        li = !lnk_ctrl_oe_n && lnk_ctrl_o == 2'h0;
  wire        lh = !lnk_ctrl_oe_n && lnk_ctrl_o == 2'h1;
  logic [7:0] hcnt;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // run length of link hold cycles
  always_ff @(posedge i_clk_sys)
    hcnt <= (i_rst || !lh) ? 8'h00 : hcnt + 8'h01;
  ////////////////////////////////////////////////////////////////
  grant_then_idle_a: assert property (pg |=> pi)
    else $error("grant not followed by one idle");
  grant_release_a: assert property (pg |=> ##1 phy_ctrl_oe_n)
    else $error("phy kept lines after grant idle");
  one_driver_a: assert property (phy_ctrl_oe_n || lnk_ctrl_oe_n)
    else $error("both ends drive the lines");
  link_no_grant_a: assert property (!lnk_ctrl_oe_n |-> lnk_ctrl_o != 2'h3)
    else $error("link drove grant code");
  lead_idle_once_a: assert property (li ##1 li |=> !lh)
    else $error("hold after two leading idles");
  hold_limit_a: assert property (hcnt <= 8'h2F)
    else $error("hold run too long");
  hold_end_a: assert property (lh ##1 !lh |-> li ##1 li ##1 lnk_ctrl_oe_n)
    else $error("hold not closed by two idles and release");
  three_idle_a: assert property (li [*3] |=> lnk_ctrl_oe_n)
    else $error("link kept lines after three idles");
  phy_reidle_a: assert property ($fell(phy_ctrl_oe_n) |-> pi ##1 !pg)
    else $error("phy resumed without idle");
  cover property (pg);
  cover property (lh [*8]);
  cover property (li [*3]);
endmodule : plc_props

// file: tb/tb_top.sv
// bench: both ends joined, null transfers and power class
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        grant = 1'b0, lead = 1'b0, wr = 1'b0;
  logic [5:0]  hold = 6'h00;
  logic [2:0]  straps = 3'h5, wdata = 3'h0;
  logic        busy, done, nul, active, ldone, concat;
  logic [31:0] self_id;
  int          n_fail = 0, total_checks = 0, n_hold = 0, n_grant = 0, cyc = 0;
  int          n_ldone = 0, n_concat = 0;
  logic [5:0]  h_in [8] = '{6'h00, 6'h00, 6'h01, 6'h05, 6'h2F, 6'h3C, 6'h02, 6'h03};
  logic [5:0]  h_exp [8] = '{6'h00, 6'h00, 6'h01, 6'h05, 6'h2F, 6'h2F, 6'h02, 6'h03};
  plc_if #(.DW(8)) bus_if ();
  plc_phy_end plc_phy_end_inst (.i_clk_sys(clk), .i_rst(rst), .bus(bus_if),
    .i_grant_req(grant), .i_power_class_straps(straps), .i_pwr_wr(wr),
    .i_pwr_wdata(wdata), .o_busy(busy), .o_done_pulse(done), .o_null_pulse(nul),
    .o_concat_pulse(concat), .o_self_id(self_id));
  plc_lnk_end plc_lnk_end_inst (.i_clk_sys(clk), .i_rst(rst), .bus(bus_if),
    .i_lead_idle(lead), .i_hold_cycles(hold), .o_active(active), .o_done_pulse(ldone));
  plc_props plc_props_inst (.i_clk_sys(clk), .i_rst(rst),
    .phy_ctrl_o(bus_if.phy_ctrl_o), .phy_ctrl_oe_n(bus_if.phy_ctrl_oe_n),
    .lnk_ctrl_o(bus_if.lnk_ctrl_o), .lnk_ctrl_oe_n(bus_if.lnk_ctrl_oe_n));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // wire-level counts of grant and hold cycles
  always @(posedge clk)
  begin
    cyc++;
    if (bus_if.iface_ctrl_lines === 2'h3) n_grant++;
    if (!bus_if.lnk_ctrl_oe_n && bus_if.iface_ctrl_lines === 2'h1) n_hold++;
    if (ldone === 1'b1) n_ldone++;
    if (concat === 1'b1) n_concat++;
    if (cyc == 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // len > 1 keeps the request up while busy: must be ignored
  task automatic xfer(input logic ld, input logic [5:0] hc, input logic [2:0] pc,
                      input logic [5:0] hx, input int len);
    int k;
    @(negedge clk);
    lead = ld; hold = hc; wr = 1'b1; wdata = pc; grant = 1'b1; n_hold = 0; n_grant = 0;
    n_ldone = 0;
    n_concat = 0;
    @(negedge clk);
    wr = 1'b0;
    repeat (len - 1) @(negedge clk);
    grant = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    check({31'h0, nul}, 32'h1);
    check(n_hold, {26'h0, hx});
    check(n_grant, 32'h1);
    check(self_id, {8'h00, pc, 21'h0});
    @(negedge clk);
    check({31'h0, busy}, 32'h0);
    check(n_ldone, 32'h1);
    check({31'h0, active}, 32'h0);
    check(n_concat, 32'h0);
  endtask : xfer
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk);
    check(self_id, 32'h0);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(self_id, 32'h00A00000);
    for (int i = 0; i < 8; i++)
      xfer(i[0], h_in[i], i[2:0], h_exp[i], 1);
    xfer(1'b0, 6'h14, 3'h2, 6'h14, 3);
    // second reset in mid-transfer reloads straps
    straps = 3'h6;
    grant = 1'b1;
    repeat (4) @(negedge clk);
    grant = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(self_id, 32'h00C00000);
    check({31'h0, busy}, 32'h0);
    xfer(1'b1, 6'h00, 3'h7, 6'h00, 1);
    final_report();
  end
endmodule : tb_top
